// >>> tcr_cfg.svh
// Constants for the tile configuration register bank.
// Assumes inclusion by the bank module only.
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH

// ------------------------------------------------------------
// Register numbers
// ------------------------------------------------------------
`define TCR_NUM_IDENT      8'h00
`define TCR_NUM_RES_ONE    8'h01
`define TCR_NUM_RES_TWO    8'h02
`define TCR_NUM_PERM       8'h04
`define TCR_NUM_DBGINT     8'h05
`define TCR_NUM_CLKDIV     8'h06
`define TCR_NUM_SECURITY   8'h07

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TCR_PERM_ALL_BIT   31
`define TCR_PERM_SW_BIT    0
`define TCR_DBG_REQ_BIT    0
`define TCR_DBG_MODE_BIT   1
`define TCR_CLK_OFF_BIT    31
`define TCR_CLK_DIV_HI     15
`define TCR_SEC_WLOCK_BIT  31
`define TCR_SEC_GDBG_BIT   14
`define TCR_SEC_OTPL_BIT   12
`define TCR_SEC_KEEP_MASK  32'h80005FB1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TCR_RST_WORD       32'h00000000
`define TCR_RST_DIV        16'h0000
`define TCR_ZERO_BYTE      8'h00

`endif

// >>> tcr_pkg.sv
// Types shared by the tile configuration register bank.
// Assumes tcr_cfg.svh sits in the same folder.
package tcr_pkg;

   // Source of a configuration access.
   typedef enum logic [1:0] {
      TCR_SRC_SWITCH,
      TCR_SRC_SCRATCH,
      TCR_SRC_SCAN
   } tcr_src_e;

   // One configuration access request.
   typedef struct packed {
      logic        valid;
      logic        write;
      tcr_src_e    source;
      logic [7:0]  regNum;
      logic [31:0] wdata;
   } tcr_req_s;

   // Answer to an access.
   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [31:0] rdata;
   } tcr_rsp_s;

endpackage

// >>> tcr_register_bank.sv
// Tile configuration register bank: identification, resource counts,
// debug permissions, debug interrupt, clock divider, security copy.
// Assumes requests are synchronous to core_clk and OTP data is stable.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_cfg.svh"

module tcr_register_bank (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Configuration access
   input  wire tcr_pkg::tcr_req_s cfgReq,
   output var  tcr_pkg::tcr_rsp_s cfgRsp,
   // Identity and resource straps
   input  wire logic [7:0]       processorId,
   input  wire logic [7:0]       nodeId,
   input  wire logic [7:0]       coreRevision,
   input  wire logic [7:0]       coreVersion,
   input  wire logic [7:0]       numChanEnds,
   input  wire logic [7:0]       numLocks,
   input  wire logic [7:0]       numSyncs,
   input  wire logic [7:0]       numClkBlocks,
   input  wire logic [7:0]       numTimers,
   // Processor and clock control
   input  wire logic             inDebugMode,
   input  wire logic             tileDivEnable,
   input  wire logic [31:0]      otpSecurity,
   output logic                  debugIrqReq,
   output logic [15:0]           clkDivValue,
   output logic                  clkDivActive,
   output logic                  tileClkStop,
   output logic                  globalDebugDeny,
   output logic                  otpAllLocked
);
   import tcr_pkg::*;

   // ---------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------
   // Debug-writable registers are the permission, interrupt and
   // divider words; reused by both write gating and the asserts.
   function automatic logic isDebugWritable(input logic [7:0] num);
      return (num == `TCR_NUM_PERM) || (num == `TCR_NUM_DBGINT) ||
             (num == `TCR_NUM_CLKDIV);
   endfunction

   logic        permAll_q,  permAll_d;
   logic        permSw_q,   permSw_d;
   logic        dbgReq_q,   dbgReq_d;
   logic        clkOff_q,   clkOff_d;
   logic [15:0] div_q,      div_d;
   logic [31:0] sec_q,      sec_d;
   tcr_rsp_s    rsp_q,      rsp_d;
   logic        irqOut_q,   irqOut_d;
   logic        gdeny_q,    gdeny_d;
   logic        otpl_q,     otpl_d;
   logic        divAct_q,   divAct_d;
   logic        wrAllowed;
   logic        doWrite;
   logic [31:0] readWord;

   // ---------------------------------------------------------
   // Write permission
   // ---------------------------------------------------------
   always_comb begin
      wrAllowed = 1'b1;
      if (permAll_q) begin
         wrAllowed = 1'b0;
      end
      if (permSw_q && cfgReq.source == TCR_SRC_SWITCH) begin
         wrAllowed = 1'b0;
      end
      doWrite = cfgReq.valid && cfgReq.write && wrAllowed &&
                isDebugWritable(cfgReq.regNum);
   end

   // ---------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------
   always_comb begin
      readWord = `TCR_RST_WORD;
      unique case (cfgReq.regNum)
         `TCR_NUM_IDENT:
            readWord = {processorId, nodeId, coreRevision,
                        coreVersion};
         `TCR_NUM_RES_ONE:
            readWord = {numChanEnds, numLocks, numSyncs,
                        `TCR_ZERO_BYTE};
         `TCR_NUM_RES_TWO:
            readWord = {`TCR_ZERO_BYTE, `TCR_ZERO_BYTE,
                        numClkBlocks, numTimers};
         `TCR_NUM_PERM: begin
            readWord[`TCR_PERM_ALL_BIT] = permAll_q;
            readWord[`TCR_PERM_SW_BIT]  = permSw_q;
         end
         `TCR_NUM_DBGINT: begin
            readWord[`TCR_DBG_REQ_BIT]  = dbgReq_q;
            readWord[`TCR_DBG_MODE_BIT] = inDebugMode;
         end
         `TCR_NUM_CLKDIV: begin
            readWord[`TCR_CLK_OFF_BIT]       = clkOff_q;
            readWord[`TCR_CLK_DIV_HI:0]      = div_q;
         end
         `TCR_NUM_SECURITY:
            readWord = sec_q;
         default:
            readWord = `TCR_RST_WORD;
      endcase
   end

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   always_comb begin
      permAll_d = permAll_q;
      permSw_d  = permSw_q;
      dbgReq_d  = dbgReq_q;
      clkOff_d  = clkOff_q;
      div_d     = div_q;
      // Security copy tracks OTP; no write path exists, which also
      // covers the write-disable bit.
      sec_d     = otpSecurity & `TCR_SEC_KEEP_MASK;
      if (doWrite) begin
         unique case (cfgReq.regNum)
            `TCR_NUM_PERM: begin
               permAll_d = cfgReq.wdata[`TCR_PERM_ALL_BIT];
               permSw_d  = cfgReq.wdata[`TCR_PERM_SW_BIT];
            end
            `TCR_NUM_DBGINT:
               dbgReq_d = cfgReq.wdata[`TCR_DBG_REQ_BIT];
            `TCR_NUM_CLKDIV: begin
               clkOff_d = cfgReq.wdata[`TCR_CLK_OFF_BIT];
               div_d    = cfgReq.wdata[`TCR_CLK_DIV_HI:0];
            end
            default: ;
         endcase
      end
      rsp_d.valid = cfgReq.valid;
      rsp_d.ack   = cfgReq.valid && (!cfgReq.write || doWrite);
      rsp_d.rdata = (cfgReq.valid && !cfgReq.write) ? readWord
                                                   : `TCR_RST_WORD;
      irqOut_d = dbgReq_d;
      gdeny_d  = sec_d[`TCR_SEC_GDBG_BIT];
      otpl_d   = sec_d[`TCR_SEC_OTPL_BIT];
      // Divide value alone does nothing until tile control enables.
      divAct_d = tileDivEnable && !clkOff_d;
   end

   // ---------------------------------------------------------
   // Registers
   // ---------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         permAll_q <= 1'b0;
         permSw_q  <= 1'b0;
         dbgReq_q  <= 1'b0;
         clkOff_q  <= 1'b0;
         div_q     <= `TCR_RST_DIV;
         sec_q     <= `TCR_RST_WORD;
         rsp_q     <= '0;
         irqOut_q  <= 1'b0;
         gdeny_q   <= 1'b0;
         otpl_q    <= 1'b0;
         divAct_q  <= 1'b0;
      end else begin
         permAll_q <= permAll_d;
         permSw_q  <= permSw_d;
         dbgReq_q  <= dbgReq_d;
         clkOff_q  <= clkOff_d;
         div_q     <= div_d;
         sec_q     <= sec_d;
         rsp_q     <= rsp_d;
         irqOut_q  <= irqOut_d;
         gdeny_q   <= gdeny_d;
         otpl_q    <= otpl_d;
         divAct_q  <= divAct_d;
      end
   end

   assign cfgRsp          = rsp_q;
   assign debugIrqReq     = irqOut_q;
   assign clkDivValue     = div_q;
   assign clkDivActive    = divAct_q;
   assign tileClkStop     = clkOff_q;
   assign globalDebugDeny = gdeny_q;
   assign otpAllLocked    = otpl_q;

   // ---------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_lock_all_writes: assert property (
      permAll_q && cfgReq.valid && cfgReq.write |=>
         !cfgRsp.ack && $stable(div_q) && $stable(dbgReq_q))
      else $error("Write taken while all debug writes locked.");
   a_switch_write_block: assert property (
      permSw_q && cfgReq.valid && cfgReq.write &&
      cfgReq.source == TCR_SRC_SWITCH |=> !cfgRsp.ack)
      else $error("Switch write taken while blocked.");
   a_irq_follows_req: assert property (
      doWrite && cfgReq.regNum == `TCR_NUM_DBGINT &&
      cfgReq.wdata[`TCR_DBG_REQ_BIT] |=> debugIrqReq)
      else $error("Debug interrupt not raised after request.");
   a_mode_readback: assert property (
      cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_DBGINT |=>
         cfgRsp.rdata[`TCR_DBG_MODE_BIT] == $past(inDebugMode))
      else $error("Debug mode bit reads wrong.");
   a_div_load: assert property (
      doWrite && cfgReq.regNum == `TCR_NUM_CLKDIV |=>
         clkDivValue == $past(cfgReq.wdata[`TCR_CLK_DIV_HI:0]))
      else $error("Divider value not loaded.");
   a_clk_stop: assert property (
      tileClkStop |-> !clkDivActive)
      else $error("Divider active while tile clock stopped.");
   a_div_needs_enable: assert property (
      !tileDivEnable |=> !clkDivActive)
      else $error("Divider active without tile enable.");
   a_sec_readonly: assert property (
      $stable(otpSecurity) [*2] |=> $stable(sec_q))
      else $error("Security copy changed without OTP change.");
   // Read checks look one cycle past the taking edge and hold the
   // answer against the inputs sampled there, the security word against OTP sampled one edge earlier;
   // the security checks skip the first cycle after reset, while the copy still holds zero.
   a_gdebug_deny: assert property (
      $past(reset_n) |->
         globalDebugDeny == $past(otpSecurity[`TCR_SEC_GDBG_BIT]))
      else $error("Global debug not denied.");
   a_otp_lock: assert property (
      $past(reset_n) |->
         otpAllLocked == $past(otpSecurity[`TCR_SEC_OTPL_BIT]))
      else $error("OTP lock not following security bit.");
   a_ident_word: assert property (
      cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_IDENT |=> cfgRsp.rdata ==
         $past({processorId, nodeId, coreRevision, coreVersion}))
      else $error("Identification word reads wrong.");
   a_res_one_word: assert property (
      cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_RES_ONE |=> cfgRsp.rdata ==
         {$past({numChanEnds, numLocks, numSyncs}), `TCR_ZERO_BYTE})
      else $error("First description word reads wrong.");
   a_res_two_word: assert property (
      cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_RES_TWO |=> cfgRsp.rdata ==
         {`TCR_ZERO_BYTE, `TCR_ZERO_BYTE,
          $past({numClkBlocks, numTimers})})
      else $error("Second description word reads wrong.");
   a_sec_copy: assert property (
      $past(reset_n) && cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_SECURITY |=> cfgRsp.rdata ==
         ($past(otpSecurity, 2) & `TCR_SEC_KEEP_MASK))
      else $error("Security word is not the masked OTP copy.");
   a_sec_no_write: assert property (
      cfgReq.valid && cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_SECURITY |=> !cfgRsp.ack)
      else $error("Write to security word was accepted.");
   a_switch_read_ok: assert property (
      permSw_q && cfgReq.valid && !cfgReq.write |=>
         cfgRsp.ack)
      else $error("Read refused while only writes are blocked.");
   a_rsp_echo: assert property (
      1'b1 |=> cfgRsp.valid == $past(cfgReq.valid))
      else $error("Answer does not follow its request.");
   a_ro_write_ignored: assert property (
      cfgReq.valid && cfgReq.write &&
      !isDebugWritable(cfgReq.regNum) |=> !cfgRsp.ack &&
         cfgRsp.rdata == `TCR_RST_WORD)
      else $error("Write to a read-only word was accepted.");
   a_perm_self_lock: assert property (
      permAll_q |=> permAll_q)
      else $error("Full write lock cleared without reset.");
   a_reserved_zero: assert property (
      cfgReq.valid && !cfgReq.write &&
      cfgReq.regNum == `TCR_NUM_RES_TWO |=> cfgRsp.rdata[31:16] == '0)
      else $error("Reserved bits not zero.");

   c_perm_write:  cover property (doWrite &&
                                  cfgReq.regNum == `TCR_NUM_PERM);
   c_irq_raise:   cover property ($rose(debugIrqReq));
   c_sw_refused:  cover property (permSw_q && cfgReq.valid &&
                                  cfgReq.write &&
                                  cfgReq.source == TCR_SRC_SWITCH);
   c_clk_stopped: cover property ($rose(tileClkStop));
   c_lock_set:    cover property ($rose(permAll_q));
endmodule
`default_nettype wire

// >>> tcr_cfg_host.sv
// Behavioural model of the party that issues configuration accesses.
// Assumes the bank answers exactly one cycle after each request.
`timescale 1ns/1ps
`default_nettype none

module tcr_cfg_host (
   // Clock
   input  wire logic              core_clk,
   // Access path
   output var  tcr_pkg::tcr_req_s cfgReq,
   input  wire tcr_pkg::tcr_rsp_s cfgRsp
);
   import tcr_pkg::*;

   initial cfgReq = '0;

   // One access by register number, held over exactly one taking edge.
   // Fields other than the source flip when idle, so a stale value never looks like a fresh one.
   task automatic access(input logic wr, input tcr_src_e src,
         input logic [7:0] num, input logic [31:0] wd,
         output logic [33:0] got);
      @(posedge core_clk);
      #1;
      cfgReq = {1'b1, wr, src, num, wd};
      @(posedge core_clk);
      #1;
      cfgReq = {1'b0, ~wr, src, ~num, ~wd};
      got = {cfgRsp.valid, cfgRsp.ack, cfgRsp.rdata};
   endtask
endmodule

`default_nettype wire

// >>> tcr_register_bank_tb.sv
// Self-checking bench for the tile configuration register bank.
// Assumes the host model in tcr_cfg_host.sv drives every access.
`timescale 1ns/1ps
`default_nettype none

module tcr_register_bank_tb;
   import tcr_pkg::*;

   typedef struct packed {
      logic        wr;
      tcr_src_e    src;
      logic [7:0]  num;
      logic [31:0] wd;
      logic [33:0] exp;
   } tcr_row_s;

   logic        core_clk      = 1'b0;
   logic        reset_n       = 1'b0;
   logic        inDebugMode   = 1'b0;
   logic        tileDivEnable = 1'b1;
   logic [31:0] otpSecurity   = 32'h80005FFF;
   logic [7:0]  strap [9]     = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                  8'h66, 8'h77, 8'h88, 8'h99};
   tcr_req_s    cfgReq;
   tcr_rsp_s    cfgRsp;
   logic        debugIrqReq, clkDivActive, tileClkStop;
   logic        globalDebugDeny, otpAllLocked;
   logic [15:0] clkDivValue;
   logic [33:0] got;
   int          n_fail    = 0;
   int          cmp_count = 0;
   tcr_row_s    rows [12];

   always #25 core_clk = ~core_clk;

   tcr_cfg_host host_u (.core_clk(core_clk), .cfgReq(cfgReq),
      .cfgRsp(cfgRsp));

   tcr_register_bank dut_u (.core_clk(core_clk), .reset_n(reset_n),
      .cfgReq(cfgReq), .cfgRsp(cfgRsp), .processorId(strap[0]),
      .nodeId(strap[1]), .coreRevision(strap[2]), .coreVersion(strap[3]),
      .numChanEnds(strap[4]), .numLocks(strap[5]), .numSyncs(strap[6]),
      .numClkBlocks(strap[7]), .numTimers(strap[8]),
      .inDebugMode(inDebugMode), .tileDivEnable(tileDivEnable),
      .otpSecurity(otpSecurity), .debugIrqReq(debugIrqReq),
      .clkDivValue(clkDivValue), .clkDivActive(clkDivActive),
      .tileClkStop(tileClkStop), .globalDebugDeny(globalDebugDeny),
      .otpAllLocked(otpAllLocked));

   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic acc(input logic wr, input tcr_src_e s,
         input logic [7:0] n, input logic [31:0] d, input logic [33:0] e);
      host_u.access(wr, s, n, d, got);
      chk(got, e);
   endtask

   // Packs every control output so one compare covers them all.
   task automatic outs(input logic [33:0] e);
      chk({13'h0, clkDivValue, tileClkStop, clkDivActive, debugIrqReq,
           globalDebugDeny, otpAllLocked}, e);
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (4000) @(posedge core_clk);
      n_fail++;
      summarize();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rows = '{
         '{0, TCR_SRC_SWITCH,  8'h00, 32'h0, 34'h311223344},
         '{0, TCR_SRC_SCRATCH, 8'h01, 32'h0, 34'h355667700},
         '{0, TCR_SRC_SCAN,    8'h02, 32'h0, 34'h300008899},
         '{1, TCR_SRC_SCAN,    8'h00, 32'hFFFFFFFF, 34'h200000000},
         '{0, TCR_SRC_SWITCH,  8'h07, 32'h0, 34'h380005FB1},
         '{1, TCR_SRC_SCRATCH, 8'h07, 32'h0, 34'h200000000},
         '{1, TCR_SRC_SCAN,    8'h06, 32'hFFFF1234, 34'h300000000},
         '{0, TCR_SRC_SWITCH,  8'h06, 32'h0, 34'h380001234},
         '{1, TCR_SRC_SWITCH,  8'h05, 32'hFFFFFFFF, 34'h300000000},
         '{0, TCR_SRC_SCAN,    8'h05, 32'h0, 34'h300000001},
         '{0, TCR_SRC_SWITCH,  8'h03, 32'h0, 34'h300000000},
         '{1, TCR_SRC_SWITCH,  8'h08, 32'h1, 34'h200000000}};
      repeat (12) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      foreach (rows[i])
         acc(rows[i].wr, rows[i].src, rows[i].num, rows[i].wd,
             rows[i].exp);
      $display("Test register table done");
      outs(34'h24697);
      acc(1, TCR_SRC_SCAN, 8'h06, 32'h5, 34'h300000000);
      outs(34'h000AF);
      tileDivEnable = 1'b0;
      otpSecurity = 32'h0;
      inDebugMode = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      outs(34'h000A4);
      acc(0, TCR_SRC_SWITCH, 8'h05, 32'h0, 34'h300000003);
      acc(0, TCR_SRC_SWITCH, 8'h07, 32'h0, 34'h300000000);
      $display("Test control outputs done");
      acc(1, TCR_SRC_SCRATCH, 8'h04, 32'h1, 34'h300000000);
      acc(1, TCR_SRC_SWITCH, 8'h06, 32'h9, 34'h200000000);
      acc(1, TCR_SRC_SCRATCH, 8'h06, 32'h9, 34'h300000000);
      acc(1, TCR_SRC_SCAN, 8'h04, 32'hFFFFFFFF, 34'h300000000);
      acc(1, TCR_SRC_SCRATCH, 8'h05, 32'h0, 34'h200000000);
      acc(1, TCR_SRC_SCAN, 8'h04, 32'h0, 34'h200000000);
      acc(0, TCR_SRC_SWITCH, 8'h04, 32'h0, 34'h380000001);
      acc(0, TCR_SRC_SWITCH, 8'h06, 32'h0, 34'h300000009);
      $display("Test permissions done");
      reset_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      outs(34'h0);
      reset_n = 1'b1;
      acc(0, TCR_SRC_SWITCH, 8'h04, 32'h0, 34'h300000000);
      acc(0, TCR_SRC_SWITCH, 8'h06, 32'h0, 34'h300000000);
      $display("Test mid-run reset done");
      summarize();
   end
endmodule

`default_nettype wire
